/* File: lcts_tx_sched.sv */
// Function
// - Send the retry command before resending the first affected header.
// - On bad header, resend every header sent after the last acknowledged one; the replay count saturates at 4.
// - Either port may request U1 or U2 with a go-to-state command.
// - Only a downstream port requests U3; an upstream port always accepts it.
// - Answer an accepted U1, U2 or U3 request with the accept command.
// - Answer a declined U1 or U2 request with reject; U3 is never rejected.
// - Requester sends power acknowledge on receiving accept, closing the handshake.
// - Downstream port sends its keep-alive every 10 us while idle in U0.
// - Upstream port sends its keep-alive every 10 us while idle in U0.
// - Never insert a link command inside any header packet.
// - Never insert a link command in a payload or between header and payload.
// - Several link commands may be sent back to back.
// - Hold link commands until all scheduled skip sets are sent.
// - In enhanced mode carry link commands in data blocks only.
// - In enhanced mode a command may start anywhere and span data blocks.
// - Send the idle symbol whenever nothing is transferred in U0.
// - Idle symbol is 00h in base mode and 5Ah in enhanced mode.
// - Idle symbols are scrambled by default.
`timescale 1ns/100ps
module lcts_tx_sched import lcts_pkg::*; #(
  parameter int KA_CYCLES = KA_CYC
) (
  input  logic       REF_CLK,
  input  logic       ARST_N,
  input  logic       U0_ACTIVE,
  input  logic       IS_DOWNSTREAM,
  input  logic       ENH_MODE,
  input  logic       BLK_DATA,
  input  logic       SKP_PENDING,
  input  logic       SCRAMBLE_DIS,
  input  logic       PKT_VALID,
  input  logic [7:0] PKT_DATA,
  input  logic       PKT_LAST,
  output logic       PKT_READY,
  input  logic       BAD_HDR,
  input  logic       HDR_ACKED,
  output logic       REPLAY_START,
  output logic [2:0] REPLAY_CNT,
  input  logic       REQ_GO,
  input  logic [1:0] REQ_STATE,
  input  logic       PM_ALLOW,
  input  logic       RX_GO,
  input  logic [1:0] RX_STATE,
  input  logic       RX_ACCEPT,
  input  logic       RX_REJECT,
  output logic       PM_PENDING,
  input  logic       TX_READY,
  output logic [7:0] TX_BYTE,
  output logic [1:0] TX_KIND,
  output logic [3:0] TX_LC_CODE,
  output logic       TX_SCRAMBLE
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  lcts_st_t             st_q;
  lcts_lc_t             cur_lc_q;
  lcts_lc_t             sel_lc;
  logic [LC_CNT_W-1:0]  lc_cnt_q;
  logic                 retry_q;
  logic                 hold_q;
  logic                 go_q;
  logic [1:0]           go_st_q;
  logic                 req_out_q;
  logic                 acc_q;
  logic                 rej_q;
  logic                 pma_q;
  logic                 ka_q;
  logic [UNACK_W-1:0]   unack_q;
  logic                 buf_vld;
  logic [BUF_W-1:0]     buf_dat;
  logic                 lc_any;
  logic                 lc_ok;
  logic                 lc_start;
  logic                 lc_step;
  logic                 lc_end;
  logic                 pkt_go;
  logic                 ka_fire;
  logic                 ka_run;
  logic                 go_ok;
  logic                 replay_q;
  logic [2:0]           rcnt_q;
  logic [7:0]           byte_q;
  lcts_kind_t           kind_q;
  logic [3:0]           code_q;
  logic                 scr_q;
  logic                 pmp_q;

  assign REPLAY_START = replay_q;
  assign REPLAY_CNT   = rcnt_q;
  assign TX_BYTE      = byte_q;
  assign TX_KIND      = kind_q;
  assign TX_LC_CODE   = code_q;
  assign TX_SCRAMBLE  = scr_q;
  assign PM_PENDING   = pmp_q;

  // ------------------------------------------------------------
  // Packet buffer
  // ------------------------------------------------------------
  lcts_buf2 #(
    .W (BUF_W)
  ) u_buf (
    .clk       (REF_CLK),
    .rst_n     (rst_n_q),
    .in_valid  (PKT_VALID),
    .in_data   ({PKT_LAST, PKT_DATA}),
    .in_ready  (PKT_READY),
    .out_valid (buf_vld),
    .out_data  (buf_dat),
    .out_ready (pkt_go)
  );

  // ------------------------------------------------------------
  // Scheduling decisions
  // ------------------------------------------------------------
  assign lc_any   = retry_q | acc_q | rej_q | pma_q | go_q | ka_q;
  assign lc_ok    = lc_any && !SKP_PENDING && (!ENH_MODE || BLK_DATA);
  // Commands only start between packets
  assign lc_start = TX_READY && st_q == ST_IDLE && lc_ok;
  assign lc_step  = TX_READY && st_q == ST_LC && (!ENH_MODE || BLK_DATA);
  assign lc_end   = lc_step && lc_cnt_q == LC_CNT_W'(LC_LEN - 1);
  assign pkt_go   = TX_READY && buf_vld
                    && ((st_q == ST_IDLE && !lc_ok && !hold_q) || st_q == ST_PKT);
  assign go_ok    = U0_ACTIVE && !go_q && !req_out_q
                    && REQ_STATE != 2'h0
                    && (REQ_STATE != PS_U3 || IS_DOWNSTREAM);

  // Priority among pending commands
  always_comb
  begin
    sel_lc = LC_NONE;
    if (retry_q)
      sel_lc = LC_RETRY;
    else if (acc_q)
      sel_lc = LC_ACCEPT;
    else if (rej_q)
      sel_lc = LC_REJECT;
    else if (pma_q)
      sel_lc = LC_PM_ACK;
    else if (go_q)
      sel_lc = go_st_q == PS_U3 ? LC_GO_U3 : (go_st_q == PS_U2 ? LC_GO_U2 : LC_GO_U1);
    else if (ka_q)
      sel_lc = IS_DOWNSTREAM ? LC_DN_ALIVE : LC_UP_ALIVE;
  end

  // ------------------------------------------------------------
  // Keep-alive
  // ------------------------------------------------------------
  assign ka_run = U0_ACTIVE && st_q == ST_IDLE && !lc_any && !buf_vld;

  lcts_ka_timer #(
    .CYC (KA_CYCLES)
  ) u_ka (
    .clk     (REF_CLK),
    .rst_n   (rst_n_q),
    .run     (ka_run),
    .restart (!U0_ACTIVE || lc_start || pkt_go),
    .fire    (ka_fire)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      st_q     <= ST_IDLE;
      cur_lc_q <= LC_NONE;
      lc_cnt_q <= '0;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
        begin
          if (lc_start)
          begin
            cur_lc_q <= sel_lc;
            lc_cnt_q <= LC_CNT_W'(1);
            st_q     <= ST_LC;
          end
          else if (pkt_go && !buf_dat[LAST_BIT])
            st_q <= ST_PKT;
        end
        ST_PKT:
        begin
          if (pkt_go && buf_dat[LAST_BIT])
            st_q <= ST_IDLE;
        end
        ST_LC:
        begin
          // Back to idle so a next command follows without gap
          if (lc_end)
            st_q <= ST_IDLE;
          else if (lc_step)
            lc_cnt_q <= lc_cnt_q + 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Symbol output
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      byte_q <= IDLE_BASE;
      kind_q <= KIND_IDLE;
      code_q <= LC_NONE;
      scr_q  <= 1'b1;
    end
    else if (TX_READY)
    begin
      if (lc_start || lc_step)
      begin
        kind_q <= KIND_LC;
        code_q <= lc_start ? sel_lc : cur_lc_q;
        byte_q <= {4'h0, lc_start ? sel_lc : cur_lc_q};
        scr_q  <= 1'b0;
      end
      else if (pkt_go)
      begin
        kind_q <= KIND_PKT;
        code_q <= LC_NONE;
        byte_q <= buf_dat[7:0];
        scr_q  <= !SCRAMBLE_DIS;
      end
      else
      begin
        kind_q <= KIND_IDLE;
        code_q <= LC_NONE;
        byte_q <= ENH_MODE ? IDLE_ENH : IDLE_BASE;
        scr_q  <= !SCRAMBLE_DIS;
      end
    end
  end

  // ------------------------------------------------------------
  // Header retry
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      retry_q  <= 1'b0;
      hold_q   <= 1'b0;
      replay_q <= 1'b0;
      rcnt_q   <= 3'h0;
    end
    else
    begin
      replay_q <= 1'b0;
      if (BAD_HDR)
      begin
        retry_q <= 1'b1;
        hold_q  <= 1'b1;
      end
      else
      begin
        if (lc_start && sel_lc == LC_RETRY)
          retry_q <= 1'b0;
        if (lc_end && cur_lc_q == LC_RETRY)
        begin
          hold_q   <= 1'b0;
          replay_q <= 1'b1;
          rcnt_q   <= unack_q;
        end
      end
    end
  end

  // Headers sent and not yet acknowledged
  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      unack_q <= '0;
    else if (replay_q)
      unack_q <= '0;
    else if (pkt_go && st_q == ST_IDLE && !HDR_ACKED && unack_q != UNACK_W'(MAX_UNACK))
      unack_q <= unack_q + 1'b1;
    else if (HDR_ACKED && !(pkt_go && st_q == ST_IDLE) && unack_q != '0)
      unack_q <= unack_q - 1'b1;
  end

  // ------------------------------------------------------------
  // Power handshake
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      go_q      <= 1'b0;
      go_st_q   <= PS_U1;
      req_out_q <= 1'b0;
      acc_q     <= 1'b0;
      rej_q     <= 1'b0;
      pma_q     <= 1'b0;
      pmp_q     <= 1'b0;
    end
    else
    begin
      if (REQ_GO && go_ok)
      begin
        go_q    <= 1'b1;
        go_st_q <= REQ_STATE;
      end
      else if (lc_start && (sel_lc == LC_GO_U1 || sel_lc == LC_GO_U2 || sel_lc == LC_GO_U3))
      begin
        go_q      <= 1'b0;
        req_out_q <= 1'b1;
      end
      else if (RX_ACCEPT || RX_REJECT)
        req_out_q <= 1'b0;
      if (RX_GO && (RX_STATE == PS_U3 || PM_ALLOW))
        acc_q <= 1'b1;
      else if (lc_start && sel_lc == LC_ACCEPT)
        acc_q <= 1'b0;
      if (RX_GO && RX_STATE != PS_U3 && !PM_ALLOW)
        rej_q <= 1'b1;
      else if (lc_start && sel_lc == LC_REJECT)
        rej_q <= 1'b0;
      if (RX_ACCEPT && req_out_q)
        pma_q <= 1'b1;
      else if (lc_start && sel_lc == LC_PM_ACK)
        pma_q <= 1'b0;
      pmp_q <= go_q || req_out_q;
    end
  end

  // Keep-alive pending flag
  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      ka_q <= 1'b0;
    else if (ka_fire && U0_ACTIVE)
      ka_q <= 1'b1;
    else if (lc_start && (sel_lc == LC_DN_ALIVE || sel_lc == LC_UP_ALIVE))
      ka_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n_q);

  chk_no_lc_in_pkt: assert property (
    (st_q == ST_PKT) |-> !lc_start && !lc_step)
    else $error("link command inside packet");
  chk_skp_first: assert property (
    lc_start |-> !SKP_PENDING)
    else $error("link command before skip set");
  chk_data_block: assert property (
    (lc_start || lc_step) |-> !ENH_MODE || BLK_DATA)
    else $error("link command outside data block");
  chk_retry_before: assert property (
    BAD_HDR |=> hold_q && retry_q)
    else $error("retry not armed after bad header");
  chk_u3_down_only: assert property (
    (lc_start && sel_lc == LC_GO_U3) |-> IS_DOWNSTREAM)
    else $error("upstream port requested U3");
  chk_u3_accept: assert property (
    (RX_GO && RX_STATE == PS_U3) |=> acc_q && !$rose(rej_q))
    else $error("U3 request not accepted");
  chk_pm_ack: assert property (
    (RX_ACCEPT && req_out_q && !(lc_start && sel_lc == LC_PM_ACK)) |=> pma_q)
    else $error("power acknowledge not queued");
  chk_idle_sym: assert property (
    (TX_READY && !lc_start && !lc_step && !pkt_go)
    |=> kind_q == KIND_IDLE && byte_q == ($past(ENH_MODE) ? IDLE_ENH : IDLE_BASE))
    else $error("wrong idle symbol");
  chk_lc_length: assert property (
    lc_start |=> (st_q == ST_LC) [*1] ##0 (lc_cnt_q == LC_CNT_W'(1)))
    else $error("link command length broken");

endmodule // lcts_tx_sched

/* File: lcts_pkg.sv */
package lcts_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ    = 10;
  localparam int KA_TIME_NS = 10000;
  // Keep-alive interval, longest time so rounded down
  localparam int KA_CYC     = KA_TIME_NS * CLK_MHZ / 1000;

  // ------------------------------------------------------------
  // Symbol stream
  // ------------------------------------------------------------
  localparam int         LC_LEN    = 4;
  localparam int         LC_CNT_W  = 3;
  localparam logic [7:0] IDLE_BASE = 8'h00;
  localparam logic [7:0] IDLE_ENH  = 8'h5a;
  localparam int         BUF_W     = 9;
  localparam int         LAST_BIT  = 8;
  localparam int         UNACK_W   = 3;
  localparam int         MAX_UNACK = 4;

  // ------------------------------------------------------------
  // Power states
  // ------------------------------------------------------------
  localparam logic [1:0] PS_U1 = 2'h1;
  localparam logic [1:0] PS_U2 = 2'h2;
  localparam logic [1:0] PS_U3 = 2'h3;

  typedef enum logic [3:0] {
    LC_NONE     = 4'h0,
    LC_RETRY    = 4'h1,
    LC_GO_U1    = 4'h2,
    LC_GO_U2    = 4'h3,
    LC_GO_U3    = 4'h4,
    LC_ACCEPT   = 4'h5,
    LC_REJECT   = 4'h6,
    LC_PM_ACK   = 4'h7,
    LC_DN_ALIVE = 4'h8,
    LC_UP_ALIVE = 4'h9
  } lcts_lc_t;

  typedef enum logic [1:0] {
    KIND_IDLE = 2'h0,
    KIND_PKT  = 2'h1,
    KIND_LC   = 2'h2
  } lcts_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PKT  = 3'b010,
    ST_LC   = 3'b100
  } lcts_st_t;

endpackage

/* File: lcts_buf2.sv */
`timescale 1ns/100ps
module lcts_buf2 import lcts_pkg::*; #(
  parameter int W = BUF_W
) (
  input  logic         clk,
  input  logic         rst_n,
  input  logic         in_valid,
  input  logic [W-1:0] in_data,
  output logic         in_ready,
  output logic         out_valid,
  output logic [W-1:0] out_data,
  input  logic         out_ready
);

  logic [W-1:0] mem_q [2];
  logic         wr_q;
  logic         rd_q;
  logic [1:0]   cnt_q;
  logic         rdy_q;
  logic         push;
  logic         pop;
  logic [1:0]   cnt_d;

  assign push      = in_valid & rdy_q;
  assign pop       = out_ready & (cnt_q != 2'h0);
  assign out_valid = cnt_q != 2'h0;
  assign out_data  = mem_q[rd_q];
  assign in_ready  = rdy_q;
  assign cnt_d     = cnt_q + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
      rdy_q <= 1'b1;
    end
    else
    begin
      wr_q  <= wr_q ^ push;
      rd_q  <= rd_q ^ pop;
      cnt_q <= cnt_d;
      rdy_q <= cnt_d != 2'h2;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  chk_buf_no_over: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_q == 2'h2) |-> !in_ready)
    else $error("buffer accepts while full");

endmodule // lcts_buf2

/* File: lcts_ka_timer.sv */
`timescale 1ns/100ps
module lcts_ka_timer import lcts_pkg::*; #(
  parameter int CYC = KA_CYC
) (
  input  logic clk,
  input  logic rst_n,
  input  logic run,
  input  logic restart,
  output logic fire
);

  localparam int CW = $clog2(CYC + 1);

  logic [CW-1:0] cnt_q;
  logic          fire_q;

  assign fire = fire_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q  <= '0;
      fire_q <= 1'b0;
    end
    else
    begin
      fire_q <= 1'b0;
      if (restart)
        cnt_q <= '0;
      else if (run && cnt_q == CW'(CYC - 1))
      begin
        cnt_q  <= '0;
        fire_q <= 1'b1;
      end
      else if (run)
        cnt_q <= cnt_q + 1'b1;
    end
  end

  chk_ka_restart: assert property (@(posedge clk) disable iff (!rst_n)
    restart |=> (cnt_q == '0) && !fire_q)
    else $error("keep-alive timer not restarted");

  chk_ka_full_wait: assert property (@(posedge clk) disable iff (!rst_n)
    fire_q |-> $past(cnt_q) == CW'(CYC - 1) && $past(run))
    else $error("keep-alive fired before full interval");

endmodule // lcts_ka_timer

/* File: lcts_link_partner.sv */
`timescale 1ns/100ps
module lcts_link_partner import lcts_pkg::*; (
  input  logic       clk,
  input  logic       rst_n,
  input  logic       slow,
  input  logic       agree,
  input  logic [1:0] tx_kind,
  input  logic [3:0] tx_lc_code,
  output logic       tx_ready,
  output logic       rx_accept,
  output logic       rx_reject,
  output logic [3:0] last_lc,
  output int         lc_seen,
  output int         pkt_seen,
  output int         bad_cmd
);
  // ------------------------------------------------------------
  // Symbol sink and power answers
  // ------------------------------------------------------------
  int         sym_q;
  logic [3:0] code_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_ready  <= 1'b1;
      rx_accept <= 1'b0;
      rx_reject <= 1'b0;
      last_lc   <= 4'h0;
      lc_seen   <= 0;
      pkt_seen  <= 0;
      bad_cmd   <= 0;
      sym_q     <= 0;
      code_q    <= 4'h0;
    end
    else
    begin
      // Slow mode takes a symbol only every other cycle
      tx_ready  <= slow ? ~tx_ready : 1'b1;
      rx_accept <= 1'b0;
      rx_reject <= 1'b0;
      if (tx_ready && tx_kind == KIND_PKT)
        pkt_seen <= pkt_seen + 1;
      if (tx_ready && tx_kind == KIND_LC)
      begin
        if (sym_q != 0 && tx_lc_code != code_q)
          bad_cmd <= bad_cmd + 1;
        code_q <= tx_lc_code;
        sym_q  <= (sym_q == LC_LEN - 1) ? 0 : sym_q + 1;
        if (sym_q == LC_LEN - 1)
        begin
          last_lc <= tx_lc_code;
          lc_seen <= lc_seen + 1;
          if (tx_lc_code inside {LC_GO_U1, LC_GO_U2, LC_GO_U3})
          begin
            rx_accept <= agree || tx_lc_code == LC_GO_U3;
            rx_reject <= !agree && tx_lc_code != LC_GO_U3;
          end
        end
      end
    end
  end
endmodule // lcts_link_partner

/* File: lcts_tx_sched_bench.sv */
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module lcts_tx_sched_bench import lcts_pkg::*; ;
  // ------------------------------------------------------------
  // Stimulus and wiring
  // ------------------------------------------------------------
  localparam int KA_T = 40;
  logic ref_clk = 1'b0, arst_n = 1'b0, u0 = 1'b1, dn = 1'b1, enh = 1'b0, blk = 1'b1;
  logic skp = 1'b0, scr_dis = 1'b0, pkt_valid = 1'b0, pkt_last = 1'b0, bad_hdr = 1'b0;
  logic hdr_acked = 1'b0, req_go = 1'b0, pm_allow = 1'b0, rx_go = 1'b0;
  logic slow = 1'b0, agree = 1'b1, prev;
  logic [7:0] pkt_data = 8'h00, tx_byte;
  logic [1:0] req_state = 2'h0, rx_state = 2'h0, tx_kind;
  logic [3:0] tx_lc_code, last_lc;
  logic [2:0] replay_cnt;
  logic pkt_ready, replay_start, rx_accept, rx_reject, pm_pending, tx_ready, tx_scramble;
  int fails = 0, check_count = 0, cyc = 0, unacked = 0, lc_seen, pkt_seen, bad_cmd;
  int rp_n = 0, rp_chk = 0;

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  // Replay pulse lasts one cycle, so count it as it happens
  always @(posedge ref_clk) if (replay_start === 1'b1) rp_n <= rp_n + 1;

  lcts_tx_sched #(.KA_CYCLES(KA_T)) lcts_tx_sched_inst (.REF_CLK(ref_clk), .ARST_N(arst_n),
    .U0_ACTIVE(u0), .IS_DOWNSTREAM(dn), .ENH_MODE(enh), .BLK_DATA(blk), .SKP_PENDING(skp),
    .SCRAMBLE_DIS(scr_dis), .PKT_VALID(pkt_valid), .PKT_DATA(pkt_data), .PKT_LAST(pkt_last),
    .PKT_READY(pkt_ready), .BAD_HDR(bad_hdr), .HDR_ACKED(hdr_acked),
    .REPLAY_START(replay_start), .REPLAY_CNT(replay_cnt), .REQ_GO(req_go),
    .REQ_STATE(req_state), .PM_ALLOW(pm_allow), .RX_GO(rx_go), .RX_STATE(rx_state),
    .RX_ACCEPT(rx_accept), .RX_REJECT(rx_reject), .PM_PENDING(pm_pending),
    .TX_READY(tx_ready), .TX_BYTE(tx_byte), .TX_KIND(tx_kind), .TX_LC_CODE(tx_lc_code),
    .TX_SCRAMBLE(tx_scramble));

  lcts_link_partner lcts_link_partner_inst (.clk(ref_clk), .rst_n(arst_n), .slow(slow),
    .agree(agree), .tx_kind(tx_kind), .tx_lc_code(tx_lc_code), .tx_ready(tx_ready),
    .rx_accept(rx_accept), .rx_reject(rx_reject), .last_lc(last_lc), .lc_seen(lc_seen),
    .pkt_seen(pkt_seen), .bad_cmd(bad_cmd));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic test_done;
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic send_unit(input int n, input logic [7:0] b);
    @(posedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      pkt_valid <= 1'b1;
      pkt_data  <= b + i[7:0];
      pkt_last  <= (i == n - 1);
      do @(posedge ref_clk); while (pkt_ready !== 1'b1);
    end
    pkt_valid <= 1'b0;
    pkt_last  <= 1'b0;
    unacked++;
  endtask

  // which: 0 partner request, 1 local request, 2 bad header, 3 header acknowledged
  task automatic strobe(input int which, input logic [1:0] s);
    @(posedge ref_clk);
    case (which)
      0: rx_go <= 1'b1;
      1: req_go <= 1'b1;
      2: bad_hdr <= 1'b1;
      default: hdr_acked <= 1'b1;
    endcase
    rx_state  <= s;
    req_state <= s;
    @(posedge ref_clk);
    {rx_go, req_go, bad_hdr, hdr_acked} <= 4'h0;
  endtask

  // Waits for the next whole command, skipping keep-alives unless one is expected
  task automatic next_lc(input logic [3:0] exp, output int t);
    int n0;
    n0 = lc_seen;
    t = 0;
    repeat (300)
    begin
      @(negedge ref_clk);
      if (lc_seen != n0)
      begin
        n0 = lc_seen;
        t = cyc;
        if (last_lc === exp || !(last_lc inside {LC_DN_ALIVE, LC_UP_ALIVE}))
          break;
      end
    end
    `CHK((t != 0) && last_lc === exp, 1'b1, "command code")
  endtask

  task automatic check_replay(input int exp);
    `CHK(rp_n, rp_chk + 1, "replay start")
    `CHK(replay_cnt, 3'((exp < MAX_UNACK) ? exp : MAX_UNACK), "replay count")
    rp_chk = rp_n;
    unacked = 0;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_idle;
    @(negedge ref_clk);
    `CHK(tx_kind, KIND_IDLE, "idle kind")
    `CHK(tx_scramble, 1'b1, "idle scrambled")
    @(posedge ref_clk);
    enh     <= 1'b1;
    scr_dis <= 1'b1;
    tick(3);
    @(negedge ref_clk);
    `CHK(tx_byte, IDLE_ENH, "enhanced idle")
    `CHK(tx_scramble, 1'b0, "scramble off")
    @(posedge ref_clk);
    enh     <= 1'b0;
    scr_dis <= 1'b0;
    tick(3);
    @(negedge ref_clk);
    `CHK(tx_byte, IDLE_BASE, "base idle")
  endtask

  task automatic t_keepalive;
    int t0, t1, n;
    next_lc(LC_DN_ALIVE, t0);
    next_lc(LC_DN_ALIVE, t1);
    `CHK((t1 - t0) >= KA_T && (t1 - t0) <= KA_T + LC_LEN + 4, 1'b1, "interval")
    @(posedge ref_clk);
    dn <= 1'b0;
    next_lc(LC_UP_ALIVE, t0);
    tick(KA_T / 2);
    send_unit(1, 8'h11);
    t0 = cyc;
    next_lc(LC_UP_ALIVE, t1);
    `CHK((t1 - t0) >= KA_T, 1'b1, "interval restart")
    @(posedge ref_clk);
    u0 <= 1'b0;
    n = lc_seen;
    tick(3 * KA_T);
    `CHK(lc_seen == n, 1'b1, "keep-alive outside U0")
    u0 <= 1'b1;
    dn <= 1'b1;
  endtask

  task automatic t_skip;
    int n, t;
    @(posedge ref_clk);
    skp      <= 1'b1;
    pm_allow <= 1'b1;
    strobe(0, PS_U1);
    n = lc_seen;
    tick(3 * KA_T);
    `CHK(lc_seen == n, 1'b1, "command during skip")
    skp <= 1'b0;
    next_lc(LC_ACCEPT, t);
  endtask

  task automatic t_retry;
    int t;
    @(posedge ref_clk);
    slow <= 1'b1;
    send_unit(2, 8'h20);
    send_unit(2, 8'h30);
    strobe(3, 2'h0);
    unacked--;
    tick(20);
    strobe(2, 2'h0);
    next_lc(LC_RETRY, t);
    check_replay(unacked);
    for (int i = 0; i < 5; i++)
      send_unit(1, 8'h50);
    tick(20);
    strobe(2, 2'h0);
    next_lc(LC_RETRY, t);
    check_replay(unacked);
    slow <= 1'b0;
  endtask

  task automatic t_b2b;
    int t0, t1;
    @(posedge ref_clk);
    pm_allow <= 1'b1;
    rx_go    <= 1'b1;
    bad_hdr  <= 1'b1;
    rx_state <= PS_U1;
    @(posedge ref_clk);
    rx_go   <= 1'b0;
    bad_hdr <= 1'b0;
    next_lc(LC_RETRY, t0);
    next_lc(LC_ACCEPT, t1);
    `CHK(t1 - t0 == LC_LEN, 1'b1, "back to back")
    unacked = 0;
  endtask

  task automatic t_place;
    int p0, t;
    p0 = pkt_seen;
    fork
      send_unit(4, 8'h40);
      begin
        tick(3);
        strobe(0, PS_U2);
      end
    join
    next_lc(LC_ACCEPT, t);
    `CHK((pkt_seen - p0) % 4 == 0, 1'b1, "command inside unit")
    tick(20);
    `CHK(pkt_seen - p0 == 4, 1'b1, "unit bytes")
  endtask

  task automatic t_power;
    int t, n;
    @(posedge ref_clk);
    pm_allow <= 1'b0;
    strobe(0, PS_U2);
    next_lc(LC_REJECT, t);
    strobe(0, PS_U3);
    next_lc(LC_ACCEPT, t);
    strobe(1, PS_U1);
    next_lc(LC_GO_U1, t);
    next_lc(LC_PM_ACK, t);
    @(posedge ref_clk);
    agree <= 1'b0;
    strobe(1, PS_U2);
    next_lc(LC_GO_U2, t);
    n = lc_seen;
    tick(6);
    `CHK(pm_pending == 1'b0 && lc_seen == n, 1'b1, "after reject")
    agree <= 1'b1;
    strobe(1, PS_U3);
    next_lc(LC_GO_U3, t);
    next_lc(LC_PM_ACK, t);
    @(posedge ref_clk);
    dn <= 1'b0;
    strobe(1, PS_U3);
    tick(4);
    `CHK(pm_pending, 1'b0, "upstream U3 request")
  endtask

  task automatic t_enh;
    int n0;
    @(posedge ref_clk);
    enh      <= 1'b1;
    pm_allow <= 1'b1;
    rx_go    <= 1'b1;
    rx_state <= PS_U2;
    n0 = lc_seen;
    repeat (40)
    begin
      @(posedge ref_clk);
      prev = blk;
      blk   <= ~blk;
      rx_go <= 1'b0;
      @(negedge ref_clk);
      if (tx_kind === KIND_LC)
        `CHK(prev, 1'b1, "command outside data block")
      if (tx_kind === KIND_LC)
        `CHK(tx_scramble, 1'b0, "command scrambled")
    end
    `CHK(lc_seen != n0 && bad_cmd == 0, 1'b1, "split command")
    enh <= 1'b0;
    blk <= 1'b1;
  endtask

  // ------------------------------------------------------------
  // Sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    tick(10);
    @(negedge ref_clk);
    `CHK(tx_byte, 8'h00, "reset symbol")
    `CHK(pkt_ready, 1'b1, "reset ready")
    @(posedge ref_clk);
    arst_n <= 1'b1;
    tick(3);
    t_idle;
    t_keepalive;
    t_skip;
    t_retry;
    t_b2b;
    t_place;
    t_power;
    t_enh;
    test_done;
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    test_done;
  end
endmodule // lcts_tx_sched_bench
